// file: include/ccm_host_pkg.sv
// constants and job layout for the packet-crypto engine controller
package ccm_host_pkg;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int unsigned PTR_W  = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // engine register offsets (byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFF_SHORTCUTS      = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_INTEGRITY      = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_ENABLE         = 12'h500;
  localparam logic [ADDR_W-1:0] OFF_MODE           = 12'h504;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_POINTER = 12'h508;
  localparam logic [ADDR_W-1:0] OFF_INPUT_POINTER  = 12'h50C;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_POINTER = 12'h510;
  localparam logic [ADDR_W-1:0] OFF_SCRATCH_POINTER = 12'h514;

  // ==========================================================================
  // field positions and values
  // ==========================================================================
  localparam logic [DATA_W-1:0] ENABLE_ON      = 32'h0000_0002;
  localparam int unsigned       MODE_DIR_POS   = 0;  // 0 encrypt, 1 decrypt
  localparam int unsigned       MODE_RATE_POS  = 1;  // data_rate_select
  localparam int unsigned       MODE_LEN_POS   = 2;  // packet_length_select
  localparam int unsigned       SHORTCUT_POS   = 0;  // keystream_to_task_a_shortcut
  localparam int unsigned       INTEGRITY_POS  = 0;  // integrity_check_result
  localparam int unsigned       NUM_WRITES     = 7;  // registers written per job
  localparam logic [2:0]        LAST_WRITE     = 3'h6;

  // ==========================================================================
  // one queued job
  // ==========================================================================
  typedef struct packed {
    logic             decrypt;   // operation mode
    logic             ext_len;   // packet_length_select
    logic             rate_2m;   // data_rate_select
    logic             shortcut;  // keystream_to_task_a_shortcut (offline jobs)
    logic             onfly;     // run alongside the radio
    logic [PTR_W-1:0] cnf_ptr;
    logic [PTR_W-1:0] in_ptr;
    logic [PTR_W-1:0] out_ptr;
    logic [PTR_W-1:0] scr_ptr;
  } job_t;

  localparam int unsigned JOB_W = $bits(job_t);

endpackage

// file: include/job_stream_if.sv
// valid/ready stream carrying job words between controller modules
`timescale 1ns/1ps
interface job_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: rtl/job_fifo.sv
// synchronous job fifo with registered ready on the filling side
`timescale 1ns/1ps
module job_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic    clk_i,
  input  wire logic    srst_i,
  job_stream_if.snk    wr_if,
  job_stream_if.src    rd_if
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          ready_r;
  logic          push;
  logic          pop;

  // ==========================================================================
  // handshakes
  // ==========================================================================
  assign push        = wr_if.valid & ready_r;
  assign pop         = rd_if.valid & rd_if.ready;
  assign wr_if.ready = ready_r;
  assign rd_if.valid = (count_r != '0);
  assign rd_if.data  = mem[rd_ptr_r];
  assign count_nxt   = count_r + (AW+1)'(push) - (AW+1)'(pop);

  // ready is a flop so the top output needs no gate behind it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b0;
    end else begin
      wr_ptr_r <= push ? AW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
      rd_ptr_r <= pop ? AW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
      count_r  <= count_nxt;
      ready_r  <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  // storage needs no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_if.data;
    end
  end

endmodule

// file: rtl/ccm_host_ctrl.sv
// controller that programs and sequences the packet-crypto engine per queued job
`timescale 1ns/1ps

module ccm_host_ctrl #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                                 CLK_SYS_I,
  input  wire logic                                 SRST_I,
  input  wire logic                                 JOB_VALID_I,
  output wire logic                                 JOB_READY_O,
  input  wire logic                                 JOB_DECRYPT_I,
  input  wire logic                                 JOB_EXT_LEN_I,
  input  wire logic                                 JOB_RATE_2M_I,
  input  wire logic                                 JOB_SHORTCUT_I,
  input  wire logic                                 JOB_ONFLY_I,
  input  wire logic [ccm_host_pkg::PTR_W-1:0]       JOB_CNF_PTR_I,
  input  wire logic [ccm_host_pkg::PTR_W-1:0]       JOB_IN_PTR_I,
  input  wire logic [ccm_host_pkg::PTR_W-1:0]       JOB_OUT_PTR_I,
  input  wire logic [ccm_host_pkg::PTR_W-1:0]       JOB_SCR_PTR_I,
  output logic                                      DONE_O,
  output logic                                      MIC_PASS_O,
  output logic                                      BUSY_O,
  input  wire logic                                 SHARED_OFF_I,
  output logic                                      REG_WR_O,
  output logic                                      REG_RD_O,
  output logic [ccm_host_pkg::ADDR_W-1:0]           REG_ADDR_O,
  output logic [ccm_host_pkg::DATA_W-1:0]           REG_WDATA_O,
  input  wire logic [ccm_host_pkg::DATA_W-1:0]      REG_RDATA_I,
  output logic                                      TASK_KEYSTREAM_GEN_TASK_O,
  output logic                                      TASK_TASK_A_O,
  input  wire logic                                 EV_KS_DONE_I,
  input  wire logic                                 EV_TASK_A_DONE_I,
  output logic                                      RADIO_START_O,
  output logic [ccm_host_pkg::PTR_W-1:0]            RADIO_PTR_O,
  output logic                                      RADIO_RATE_2M_O,
  input  wire logic                                 RADIO_ADDR_I
);
  import ccm_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_SHARED, S_WRITE, S_KEYSTREAM_GEN_TASK, S_WAIT_KS, S_WAIT_ADDR,
    S_TASK_A, S_WAIT_TASK_A, S_READ_MIC, S_MIC_WAIT, S_TAKE_MIC
  } state_t;

  state_t                  state_r;
  state_t                  state_nxt;
  job_t                    job_r;
  logic [2:0]              idx_r;
  logic [2:0]              wr_idx_r;
  logic [NUM_WRITES-1:0]   wrote_r;
  logic                    addr_seen_r;
  logic                    ks_fresh_r;
  logic                    shared_seen_r;
  logic                    pop;
  logic                    sc_eff;
  logic                    done_set;
  logic [DATA_W-1:0]       mode_word;
  logic [ADDR_W-1:0]       tab_addr [NUM_WRITES];
  logic [DATA_W-1:0]       tab_data [NUM_WRITES];

  job_stream_if #(.W(JOB_W)) in_if ();
  job_stream_if #(.W(JOB_W)) out_if ();

  // ==========================================================================
  // job queue
  // ==========================================================================
  assign in_if.valid  = JOB_VALID_I;
  assign in_if.data   = {JOB_DECRYPT_I, JOB_EXT_LEN_I, JOB_RATE_2M_I, JOB_SHORTCUT_I,
                         JOB_ONFLY_I, JOB_CNF_PTR_I, JOB_IN_PTR_I, JOB_OUT_PTR_I,
                         JOB_SCR_PTR_I};
  assign JOB_READY_O  = in_if.ready;
  assign pop          = (state_r == S_IDLE) & out_if.valid;
  assign out_if.ready = (state_r == S_IDLE);

  job_fifo #(.W(JOB_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .wr_if  (in_if),
    .rd_if  (out_if)
  );

  // ==========================================================================
  // register image written for every job
  // ==========================================================================
  // on-the-fly transmit must chain task_a to keystream; on-the-fly receive must
  // wait for the address event, so the chain is forced off there
  assign sc_eff    = job_r.onfly ? ~job_r.decrypt : job_r.shortcut;
  assign mode_word = (DATA_W'(job_r.decrypt) << MODE_DIR_POS)
                   | (DATA_W'(job_r.rate_2m) << MODE_RATE_POS)
                   | (DATA_W'(job_r.ext_len) << MODE_LEN_POS);
  // all seven registers every time: shared registers may hold stale values
  assign tab_addr[0] = OFF_ENABLE;
  assign tab_data[0] = ENABLE_ON;
  assign tab_addr[1] = OFF_MODE;
  assign tab_data[1] = mode_word;
  assign tab_addr[2] = OFF_CONFIG_POINTER;
  assign tab_data[2] = job_r.cnf_ptr;
  assign tab_addr[3] = OFF_INPUT_POINTER;
  assign tab_data[3] = job_r.in_ptr;
  assign tab_addr[4] = OFF_OUTPUT_POINTER;
  assign tab_data[4] = job_r.out_ptr;
  assign tab_addr[5] = OFF_SCRATCH_POINTER;
  assign tab_data[5] = job_r.scr_ptr;
  assign tab_addr[6] = OFF_SHORTCUTS;
  assign tab_data[6] = DATA_W'(sc_eff) << SHORTCUT_POS;

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:        if (pop) state_nxt = S_WAIT_SHARED;
      S_WAIT_SHARED: if (SHARED_OFF_I) state_nxt = S_WRITE;
      S_WRITE:       if (idx_r == LAST_WRITE) state_nxt = S_KEYSTREAM_GEN_TASK;
      S_KEYSTREAM_GEN_TASK:       state_nxt = S_WAIT_KS;
      S_WAIT_KS: begin
        if (EV_KS_DONE_I) begin
          if (sc_eff) state_nxt = S_WAIT_TASK_A;
          else if (job_r.onfly) state_nxt = S_WAIT_ADDR;
          else state_nxt = S_TASK_A;
        end
      end
      S_WAIT_ADDR:   if (addr_seen_r) state_nxt = S_TASK_A;
      S_TASK_A:       state_nxt = S_WAIT_TASK_A;
      S_WAIT_TASK_A: begin
        if (EV_TASK_A_DONE_I) state_nxt = job_r.decrypt ? S_READ_MIC : S_IDLE;
      end
      S_READ_MIC:    state_nxt = S_MIC_WAIT;
      S_MIC_WAIT:    state_nxt = S_TAKE_MIC;
      S_TAKE_MIC:    state_nxt = S_IDLE;
      default:       state_nxt = S_IDLE;
    endcase
  end

  assign done_set = (state_r == S_TAKE_MIC)
                  | ((state_r == S_WAIT_TASK_A) & EV_TASK_A_DONE_I & ~job_r.decrypt);

  // state, job and bookkeeping flags
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_r       <= S_IDLE;
      job_r         <= '0;
      idx_r         <= '0;
      wr_idx_r      <= '0;
      wrote_r       <= '0;
      addr_seen_r   <= 1'b0;
      shared_seen_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      job_r         <= pop ? job_t'(out_if.data) : job_r;
      // index returns to zero after the last entry so the table is never read past its end
      idx_r         <= ((state_r == S_WRITE) && (idx_r != LAST_WRITE)) ? idx_r + 3'h1 : 3'h0;
      // the strobe lags the index by one cycle, so mark the entry it really carries
      wr_idx_r      <= idx_r;
      wrote_r       <= pop ? '0 : wrote_r | (REG_WR_O ? NUM_WRITES'(1) << wr_idx_r : '0);
      // an address event seen early still counts, but never from a previous job
      addr_seen_r   <= ~pop & (addr_seen_r | (RADIO_ADDR_I & (state_r != S_IDLE)));
      shared_seen_r <= ~pop & (shared_seen_r | ((state_r == S_WAIT_SHARED) & SHARED_OFF_I));
    end
  end

  // keystream freshness: an arriving done wins over a same-cycle consume
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ks_fresh_r <= 1'b0;
    end else begin
      ks_fresh_r <= EV_KS_DONE_I | (ks_fresh_r & ~TASK_TASK_A_O & ~EV_TASK_A_DONE_I);
    end
  end

  // ==========================================================================
  // registered outputs, one cycle behind the state that asks for them; BUSY_O is taken from the next state, so it tracks the state in step
  // ==========================================================================
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      REG_WR_O        <= 1'b0;
      REG_RD_O        <= 1'b0;
      REG_ADDR_O      <= '0;
      REG_WDATA_O     <= '0;
      TASK_KEYSTREAM_GEN_TASK_O    <= 1'b0;
      TASK_TASK_A_O    <= 1'b0;
      RADIO_START_O   <= 1'b0;
      RADIO_PTR_O     <= '0;
      RADIO_RATE_2M_O <= 1'b0;
      DONE_O          <= 1'b0;
      MIC_PASS_O      <= 1'b0;
      BUSY_O          <= 1'b0;
    end else begin
      REG_WR_O        <= (state_r == S_WRITE);
      REG_RD_O        <= (state_r == S_READ_MIC);
      REG_ADDR_O      <= (state_r == S_READ_MIC) ? OFF_INTEGRITY : tab_addr[idx_r];
      REG_WDATA_O     <= tab_data[idx_r];
      TASK_KEYSTREAM_GEN_TASK_O    <= (state_r == S_KEYSTREAM_GEN_TASK);
      TASK_TASK_A_O    <= (state_r == S_TASK_A);
      RADIO_START_O   <= (state_r == S_KEYSTREAM_GEN_TASK) & job_r.onfly;
      RADIO_PTR_O     <= job_r.decrypt ? job_r.in_ptr : job_r.out_ptr;
      RADIO_RATE_2M_O <= job_r.rate_2m;
      DONE_O          <= done_set;
      // encryption has no tag check, so it reports a pass
      MIC_PASS_O      <= (state_r == S_TAKE_MIC) ? REG_RDATA_I[INTEGRITY_POS] :
                         (done_set ? 1'b1 : MIC_PASS_O);
      BUSY_O          <= (state_nxt != S_IDLE);
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_task_a_after_fresh_ks;
    @(posedge CLK_SYS_I) disable iff (SRST_I) TASK_TASK_A_O |-> ks_fresh_r;
  endproperty
  a_task_a_after_fresh_ks: assert property (p_task_a_after_fresh_ks)
    else $error("task_a task without a fresh keystream");

  property p_cfg_before_ks;
    @(posedge CLK_SYS_I) disable iff (SRST_I) TASK_KEYSTREAM_GEN_TASK_O |-> wrote_r[1] && wrote_r[2];
  endproperty
  a_cfg_before_ks: assert property (p_cfg_before_ks)
    else $error("keystream started before mode and config pointer were written");

  property p_ptrs_before_task_a;
    @(posedge CLK_SYS_I) disable iff (SRST_I) TASK_TASK_A_O |-> wrote_r[3] && wrote_r[4];
  endproperty
  a_ptrs_before_task_a: assert property (p_ptrs_before_task_a)
    else $error("task_a task before input and output pointers were written");

  property p_ptrs_before_shortcut_ks;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      TASK_KEYSTREAM_GEN_TASK_O && sc_eff |-> wrote_r[3] && wrote_r[4] && wrote_r[6];
  endproperty
  a_ptrs_before_shortcut_ks: assert property (p_ptrs_before_shortcut_ks)
    else $error("chained keystream started before pointers were written");

  property p_write_after_shared_off;
    @(posedge CLK_SYS_I) disable iff (SRST_I) REG_WR_O |-> shared_seen_r;
  endproperty
  a_write_after_shared_off: assert property (p_write_after_shared_off)
    else $error("engine register written before shared peripherals were off");

  property p_all_regs_written;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      $rose(REG_WR_O) |-> ##7 (TASK_KEYSTREAM_GEN_TASK_O && (&wrote_r));
  endproperty
  a_all_regs_written: assert property (p_all_regs_written)
    else $error("keystream not started with every register written");

  property p_radio_start_with_ks;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      RADIO_START_O |-> TASK_KEYSTREAM_GEN_TASK_O && (job_r.decrypt || sc_eff)
                        && RADIO_RATE_2M_O == job_r.rate_2m;
  endproperty
  a_radio_start_with_ks: assert property (p_radio_start_with_ks)
    else $error("radio started before keystream or without the shortcut");

  property p_radio_ptr_match;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      RADIO_START_O |-> RADIO_PTR_O == (job_r.decrypt ? job_r.in_ptr : job_r.out_ptr);
  endproperty
  a_radio_ptr_match: assert property (p_radio_ptr_match)
    else $error("radio packet pointer does not match the engine pointer");

  property p_rx_task_a_after_addr;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
      TASK_TASK_A_O && job_r.onfly && job_r.decrypt |-> addr_seen_r;
  endproperty
  a_rx_task_a_after_addr: assert property (p_rx_task_a_after_addr)
    else $error("receive task_a task issued before the radio address event");

endmodule

// file: testbench/ccm_engine_model.sv
// behavioural packet-crypto engine seen through its register and task pins
`timescale 1ns/1ps
module ccm_engine_model (
  input  wire logic                            clk_i,
  input  wire logic                            srst_i,
  input  wire logic                            wr_i,
  input  wire logic                            rd_i,
  input  wire logic [ccm_host_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ccm_host_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                            ks_i,
  input  wire logic                            cr_i,
  input  wire logic [3:0]                      dly_i,
  output logic [ccm_host_pkg::DATA_W-1:0]      rdata_o,
  output wire logic                            ks_done_o,
  output wire logic                            cr_done_o,
  output wire logic                            stale_o
);
  import ccm_host_pkg::*;
  logic [2:0]        mode_r;
  logic              sc_r, mic_r, fresh_r;
  logic [DATA_W-1:0] in_r;
  logic [4:0]        ks_r, cr_r;
  // task_a starts on its task, or by itself on keystream done with the shortcut set
  wire go = cr_i | (ks_done_o & sc_r);
  assign ks_done_o = (ks_r == 5'h01);
  assign cr_done_o = (cr_r == 5'h01);
  assign stale_o   = go & ~(fresh_r | ks_done_o);
  // registers keep their last write; delays follow dly_i so answers come fast or slow
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r  <= 3'h1;
      sc_r    <= 1'b0;
      mic_r   <= 1'b0;
      fresh_r <= 1'b0;
      in_r    <= '0;
      ks_r    <= '0;
      cr_r    <= '0;
      rdata_o <= '0;
    end else begin
      if (wr_i && addr_i == OFF_MODE) mode_r <= wdata_i[2:0];
      if (wr_i && addr_i == OFF_SHORTCUTS) sc_r <= wdata_i[0];
      if (wr_i && addr_i == OFF_INPUT_POINTER) in_r <= wdata_i;
      // task_a time is bounded by dly_i, well inside any packet air time
      ks_r    <= ks_i ? {1'b0, dly_i} + 5'h02 : ks_r - {4'h0, |ks_r};
      cr_r    <= go ? {1'b0, dly_i} + 5'h02 : cr_r - {4'h0, |cr_r};
      fresh_r <= ks_done_o | (fresh_r & ~go);
      // ram is not modelled: pointer bit 4 stands in for the tag verdict
      // packet and key layout, length adjust and empty copy live in ram
      // structure offsets are not fetched here
      if (cr_done_o) mic_r <= mode_r[0] & in_r[4];
      // read data changes every idle cycle so a late sample never looks valid
      rdata_o <= rd_i ? {31'h0, mic_r & (addr_i == OFF_INTEGRITY)} : ~rdata_o;
    end
  end
endmodule

// file: testbench/test_ccm_host_ctrl.sv
// self-checking bench for the packet-crypto engine controller
`timescale 1ns/1ps
module test_ccm_host_ctrl;
  import ccm_host_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, jv = 1'b0, sh_off = 1'b1, r_addr = 1'b0;
  logic [3:0]        dly = 4'h0;
  job_t              jin = '0, j;
  logic              rdy, done, mic, busy, wr, rd, ks, cr, ksd, crd, rstart, rrate, stale, ok;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rdat;
  logic [PTR_W-1:0]  rptr;
  logic [159:0]      rnd;
  int                err_total = 0, n_checks = 0, widx = 0, n_acc = 0, n_done = 0, rc = 0;
  int                nok;
  bit                seen_addr = 0;
  job_t              jq[$];
  always #4 clk = ~clk;
  ccm_host_ctrl i_dut (.CLK_SYS_I(clk), .SRST_I(rst), .JOB_VALID_I(jv), .JOB_READY_O(rdy),
    .JOB_DECRYPT_I(jin.decrypt), .JOB_EXT_LEN_I(jin.ext_len), .JOB_RATE_2M_I(jin.rate_2m),
    .JOB_SHORTCUT_I(jin.shortcut), .JOB_ONFLY_I(jin.onfly), .JOB_CNF_PTR_I(jin.cnf_ptr),
    .JOB_IN_PTR_I(jin.in_ptr), .JOB_OUT_PTR_I(jin.out_ptr), .JOB_SCR_PTR_I(jin.scr_ptr),
    .DONE_O(done), .MIC_PASS_O(mic), .BUSY_O(busy), .SHARED_OFF_I(sh_off), .REG_WR_O(wr),
    .REG_RD_O(rd), .REG_ADDR_O(addr), .REG_WDATA_O(wd), .REG_RDATA_I(rdat),
    .TASK_KEYSTREAM_GEN_TASK_O(ks), .TASK_TASK_A_O(cr), .EV_KS_DONE_I(ksd), .EV_TASK_A_DONE_I(crd),
    .RADIO_START_O(rstart), .RADIO_PTR_O(rptr), .RADIO_RATE_2M_O(rrate), .RADIO_ADDR_I(r_addr));
  ccm_engine_model i_eng (.clk_i(clk), .srst_i(rst), .wr_i(wr), .rd_i(rd), .addr_i(addr),
    .wdata_i(wd), .ks_i(ks), .cr_i(cr), .dly_i(dly), .rdata_o(rdat), .ks_done_o(ksd),
    .cr_done_o(crd), .stale_o(stale));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [43:0] exp_wr(job_t x, int i);
    case (i)
      0: return {OFF_ENABLE, ENABLE_ON};
      1: return {OFF_MODE, 29'h0, x.ext_len, x.rate_2m, x.decrypt};
      2: return {OFF_CONFIG_POINTER, x.cnf_ptr};
      3: return {OFF_INPUT_POINTER, x.in_ptr};
      4: return {OFF_OUTPUT_POINTER, x.out_ptr};
      5: return {OFF_SCRATCH_POINTER, x.scr_ptr};
      default: return {OFF_SHORTCUTS, 31'h0, x.onfly ? ~x.decrypt : x.shortcut};
    endcase
  endfunction
  // ==========================================================================
  // scoreboard: each register write, keystream, task_a and done strobe is compared against the oldest queued job
  // ==========================================================================
  always @(posedge clk) begin
    if (!rst) begin
      if (jv && rdy) jq.push_back(jin);
      if (r_addr) seen_addr = 1'b1;
      if (stale) check(1, 0);
      if (wr) begin
        check(sh_off, 1);
        check({addr, wd}, exp_wr(jq[0], widx));
        widx++;
      end
      if (ks) begin
        check(widx, NUM_WRITES);
        check(rstart, jq[0].onfly);
        if (jq[0].onfly) begin
          check(rptr, jq[0].decrypt ? jq[0].in_ptr : jq[0].out_ptr);
          check(rrate, jq[0].rate_2m);
        end
      end
      if (cr) check(exp_wr(jq[0], 6) | {43'h0, jq[0].onfly & ~seen_addr},
        {OFF_SHORTCUTS, 32'h0});
      if (done) begin
        check(mic, jq[0].decrypt ? jq[0].in_ptr[4] : 1'b1);
        void'(jq.pop_front());
        widx = 0;
        seen_addr = 0;
        n_done++;
      end
    end
  end
  // radio side: address event a few cycles after radio start on receive jobs
  always @(posedge clk) begin
    dly <= 4'($urandom_range(15, 0));
    r_addr <= (rc == 1);
    if (rstart && jq[0].decrypt) rc = 2 + $urandom_range(8, 0);
    else if (rc > 0) rc--;
  end
  task automatic offer(input job_t x, output logic acc);
    int n;
    @(posedge clk);
    jin <= x;
    jv <= 1'b1;
    acc = 1'b0;
    for (n = 0; n < 400 && !acc; n++) begin
      @(negedge clk);
      acc = (rdy === 1'b1);
      @(posedge clk);
    end
    jv <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((jq.size() != 0 || busy !== 1'b0) && n < 4000);
    check(n < 4000, 1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(40000 * 8);
    err_total++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h1dae8cac));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // corner jobs back to back: task path, shortcut path, on-fly transmit and receive
    for (int k = 0; k < 4; k++) begin
      j = '0;
      j.decrypt = k[0];
      j.shortcut = k[0];
      j.onfly = k[1];
      j.ext_len = k[1];
      j.in_ptr = 32'h2000_0010 + 32'(k);
      offer(j, ok);
    end
    wait_idle();
    $display("test corner jobs done");
    for (int k = 0; k < 16; k++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
      offer(rnd[JOB_W-1:0], ok);
    end
    wait_idle();
    $display("test random jobs done");
    // queue fills while shared peripherals stay on: one job held plus a full fifo
    @(posedge clk);
    sh_off <= 1'b0;
    nok = 0;
    for (int k = 0; k < 10; k++) begin
      offer(rnd[JOB_W-1:0] ^ JOB_W'(k), ok);
      nok += int'(ok);
    end
    check(nok, 9);
    sh_off <= 1'b1;
    wait_idle();
    check(n_done, 29);
    check(n_acc, 29);
    $display("test fifo fill done");
    complete_run();
  end
  always @(posedge clk) if (jv && rdy && !rst) n_acc++;
endmodule
